/* hdl/dac_load_device.sv */
// Purpose: serial load port of a current-output dac, device end
// Assumes: host keeps sclk still outside frames and low-to-high sync is clean
// Notes: link logic runs on sclk, dac register on i_clk
// Function
// - three host wires: clock, data, active-low sync
// - one sixteen-bit word per low sync frame
// - falling edge by default, control word selects edge
// - dac output updates on sync rising edge
// - data travels most significant bit first
// - host lowers sync before first active edge
// - byte hosts hold sync low across two bytes
// - host changes data on opposite clock edge
// - shift register shifts out on rising edges
`timescale 1ns/1ps
`include "dac_link_consts.svh"

module dac_load_device #(
  parameter int DAC_BITS = 12
) (
  // link
  dac_link_if.dev link,
  // system
  input wire logic i_clk,
  input wire logic i_resetn,
  // dac side
  output logic [DAC_BITS-1:0] o_dac_code,
  output logic o_update,
  output logic o_sample_rising
);
  import dac_link_pkg::*;

  function automatic logic [`CNT_BITS-1:0] cnt_step(input logic [`CNT_BITS-1:0] cnt);
    // saturate at a full word so long frames keep the last sixteen bits
    if (cnt == `CNT_BITS'(`WORD_BITS)) begin
      cnt_step = cnt;
    end else begin
      cnt_step = cnt + `CNT_BITS'(1);
    end
  endfunction : cnt_step

  // sync high clears the frame state without needing an sclk edge,
  // since the host stops the clock between frames
  logic frame_clr_n;
  assign frame_clr_n = i_resetn & ~link.sync_n;

  // falling-edge sampling path (default)
  word_t shift_fall_ff;
  word_t hold_fall_ff;
  logic [`CNT_BITS-1:0] cnt_fall_ff;
  logic done_fall_ff;
  word_t nxt_shift_fall;
  logic [`CNT_BITS-1:0] nxt_cnt_fall;

  assign nxt_shift_fall = {shift_fall_ff[`WORD_BITS-2:0], link.din};
  assign nxt_cnt_fall = cnt_step(cnt_fall_ff);

  always_ff @(negedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_fall_ff <= `SHIFT_RST;
    end else if (!link.sync_n) begin
      shift_fall_ff <= nxt_shift_fall;
    end
  end

  always_ff @(negedge link.sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      cnt_fall_ff <= '0;
    end else begin
      cnt_fall_ff <= nxt_cnt_fall;
    end
  end

  always_ff @(negedge link.sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      done_fall_ff <= 1'b0;
    end else if (nxt_cnt_fall == `CNT_BITS'(`WORD_BITS)) begin
      done_fall_ff <= 1'b1;
    end
  end

  always_ff @(negedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_fall_ff <= `SHIFT_RST;
    end else if (!link.sync_n && nxt_cnt_fall == `CNT_BITS'(`WORD_BITS)) begin
      hold_fall_ff <= nxt_shift_fall;
    end
  end

  // rising-edge sampling path, chosen by a control word
  word_t shift_rise_ff;
  word_t hold_rise_ff;
  logic [`CNT_BITS-1:0] cnt_rise_ff;
  logic done_rise_ff;
  word_t nxt_shift_rise;
  logic [`CNT_BITS-1:0] nxt_cnt_rise;

  assign nxt_shift_rise = {shift_rise_ff[`WORD_BITS-2:0], link.din};
  assign nxt_cnt_rise = cnt_step(cnt_rise_ff);

  always_ff @(posedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_rise_ff <= `SHIFT_RST;
    end else if (!link.sync_n) begin
      shift_rise_ff <= nxt_shift_rise;
    end
  end

  always_ff @(posedge link.sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      cnt_rise_ff <= '0;
    end else begin
      cnt_rise_ff <= nxt_cnt_rise;
    end
  end

  always_ff @(posedge link.sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      done_rise_ff <= 1'b0;
    end else if (nxt_cnt_rise == `CNT_BITS'(`WORD_BITS)) begin
      done_rise_ff <= 1'b1;
    end
  end

  always_ff @(posedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_rise_ff <= `SHIFT_RST;
    end else if (!link.sync_n && nxt_cnt_rise == `CNT_BITS'(`WORD_BITS)) begin
      hold_rise_ff <= nxt_shift_rise;
    end
  end

  // readback follows the default falling-edge register only
  logic sdo_ff;

  always_ff @(posedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sdo_ff <= 1'b0;
    end else if (!link.sync_n) begin
      sdo_ff <= shift_fall_ff[`WORD_BITS-1];
    end
  end

  assign link.serial_data_out = sdo_ff;

  // system-clock side: synchronise sync and the two done levels
  logic sync_s1_ff;
  logic sync_s2_ff;
  logic sync_s3_ff;
  logic done_fall_s1_ff;
  logic done_fall_s2_ff;
  logic done_rise_s1_ff;
  logic done_rise_s2_ff;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_s1_ff <= 1'b1;
      sync_s2_ff <= 1'b1;
      sync_s3_ff <= 1'b1;
    end else begin
      sync_s1_ff <= link.sync_n;
      sync_s2_ff <= sync_s1_ff;
      sync_s3_ff <= sync_s2_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_fall_s1_ff <= 1'b0;
      done_fall_s2_ff <= 1'b0;
      done_rise_s1_ff <= 1'b0;
      done_rise_s2_ff <= 1'b0;
    end else begin
      done_fall_s1_ff <= done_fall_ff;
      done_fall_s2_ff <= done_fall_s1_ff;
      done_rise_s1_ff <= done_rise_ff;
      done_rise_s2_ff <= done_rise_s1_ff;
    end
  end

  logic sync_rise;
  logic done_sel;
  logic armed_ff;
  word_t word_sel;

  assign sync_rise = sync_s2_ff & ~sync_s3_ff;
  assign done_sel = o_sample_rising ? done_rise_s2_ff : done_fall_s2_ff;
  // hold words are read only at sync rise once done is seen; after the frame's last sclk edge they
  // cannot move again before the next frame completes, so no word synchroniser is needed
  assign word_sel = o_sample_rising ? hold_rise_ff : hold_fall_ff;

  // armed only ever sets while sync is low: done drops with sync rising,
  // and the two may be seen here in either order
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      armed_ff <= 1'b0;
    end else if (sync_rise) begin
      armed_ff <= 1'b0;
    end else if (!sync_s2_ff && done_sel) begin
      armed_ff <= 1'b1;
    end
  end

  logic load_word;
  logic is_edge_ctrl;

  assign load_word = sync_rise & armed_ff;
  assign is_edge_ctrl = word_sel[`CTRL_MSB:`CTRL_LSB] == `CTRL_EDGE_SEL;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sample_rising <= 1'b0;
    end else if (load_word && is_edge_ctrl) begin
      o_sample_rising <= word_sel[`EDGE_SEL_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_dac_code <= DAC_BITS'(`DAC_CODE_RST);
    end else if (load_word && !is_edge_ctrl) begin
      o_dac_code <= word_sel[DAC_BITS-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_update <= 1'b0;
    end else begin
      o_update <= load_word && !is_edge_ctrl;
    end
  end

endmodule : dac_load_device

/* hdl/dac_link_consts.svh */
// Purpose: shared constants of the serial DAC load link
// Assumes: system clock of 4 ns on both ends
// Notes: control codes are used by the device and the testbench only, timing figures by the host only
`ifndef DAC_LINK_CONSTS_SVH
`define DAC_LINK_CONSTS_SVH

// word layout
`define WORD_BITS 16
`define BYTE_BITS 8
`define CNT_BITS 5
`define CTRL_MSB 15
`define CTRL_LSB 12
`define EDGE_SEL_BIT 0
// control code that selects the sampling edge; any other code loads the dac
`define CTRL_EDGE_SEL 4'hE

// reset values
`define DAC_CODE_RST 16'h0000
`define SHIFT_RST 16'h0000

// timing
`define CLK_PERIOD_NS 4
`define T_SYNC_SETUP_NS 13
`define SYNC_SETUP_CYC ((`T_SYNC_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HALF_SCLK_CYC 20
`define BYTE_GAP_CYC 8
`define FRAME_GAP_CYC 8

`endif

/* hdl/dac_link_pkg.sv */
// Purpose: types shared by both ends of the serial DAC load link
// Assumes: constants come from dac_link_consts.svh
// Notes: none
package dac_link_pkg;

  typedef logic [15:0] word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_SHIFT = 3'b010,
    ST_GAP = 3'b011,
    ST_TRAIL = 3'b100,
    ST_REST = 3'b101
  } host_state_t;

endpackage : dac_link_pkg

/* hdl/dac_link_if.sv */
// Purpose: three host-driven wires plus readback between host and device
// Assumes: host owns the serial clock
// Notes: all wires are single-driver, no tristate
`timescale 1ns/1ps
interface dac_link_if;
  logic sync_n;
  logic sclk;
  logic din;
  logic serial_data_out;

  modport host (
    output sync_n,
    output sclk,
    output din,
    input serial_data_out
  );

  modport dev (
    input sync_n,
    input sclk,
    input din,
    output serial_data_out
  );
endinterface : dac_link_if

/* hdl/dac_load_host.sv */
// Purpose: host end that frames and shifts words into the dac load port
// Assumes: serial clock is made here by dividing i_clk
// Notes: sclk idles low; one word per start request
`timescale 1ns/1ps
`include "dac_link_consts.svh"

module dac_load_host #(
  parameter int HALF_CYC = `HALF_SCLK_CYC,
  parameter int GAP_CYC = `BYTE_GAP_CYC
) (
  // system
  input wire logic i_clk,
  input wire logic i_resetn,
  // request
  input wire logic i_start,
  input wire dac_link_pkg::word_t i_word,
  input wire logic i_byte_mode,
  input wire logic i_sample_rising,
  // status
  output logic o_busy,
  output dac_link_pkg::word_t o_readback,
  // link
  dac_link_if.host link
);
  import dac_link_pkg::*;

  host_state_t state_ff;
  logic [7:0] tmr_ff;
  logic [`CNT_BITS-1:0] bits_ff;
  word_t tx_ff;
  word_t rx_ff;
  logic rise_mode_ff;
  logic sclk_ff;
  logic sync_n_ff;
  logic din_ff;
  logic sdo_s1_ff;
  logic sdo_s2_ff;

  logic tmr_done;
  logic toggle;
  assign tmr_done = tmr_ff == 8'h00;
  assign toggle = state_ff == ST_SHIFT && tmr_done;

  assign link.sclk = sclk_ff;
  assign link.sync_n = sync_n_ff;
  assign link.din = din_ff;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sdo_s1_ff <= 1'b0;
      sdo_s2_ff <= 1'b0;
    end else begin
      sdo_s1_ff <= link.serial_data_out;
      sdo_s2_ff <= sdo_s1_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= ST_IDLE;
      tmr_ff <= 8'h00;
      bits_ff <= '0;
      tx_ff <= `SHIFT_RST;
      rise_mode_ff <= 1'b0;
      sync_n_ff <= 1'b1;
      sclk_ff <= 1'b0;
      din_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (i_start) begin
            state_ff <= ST_LEAD;
            sync_n_ff <= 1'b0;
            tx_ff <= i_word;
            din_ff <= i_word[`WORD_BITS-1];
            rise_mode_ff <= i_sample_rising;
            bits_ff <= '0;
            tmr_ff <= 8'(`SYNC_SETUP_CYC > HALF_CYC ? `SYNC_SETUP_CYC : HALF_CYC);
          end
        end
        ST_LEAD: begin
          if (tmr_done) begin
            state_ff <= ST_SHIFT;
          end else begin
            tmr_ff <= tmr_ff - 8'h01;
          end
        end
        ST_SHIFT: begin
          if (!tmr_done) begin
            tmr_ff <= tmr_ff - 8'h01;
          end else if (!sclk_ff) begin
            sclk_ff <= 1'b1;
            tmr_ff <= 8'(HALF_CYC - 1);
            if (!rise_mode_ff && bits_ff != '0) begin
              din_ff <= tx_ff[`WORD_BITS-1];
            end
          end else begin
            sclk_ff <= 1'b0;
            tmr_ff <= 8'(HALF_CYC - 1);
            bits_ff <= bits_ff + `CNT_BITS'(1);
            tx_ff <= {tx_ff[`WORD_BITS-2:0], 1'b0};
            if (rise_mode_ff) begin
              din_ff <= tx_ff[`WORD_BITS-2];
            end
            if (bits_ff == `CNT_BITS'(`WORD_BITS - 1)) begin
              state_ff <= ST_TRAIL;
            end else if (i_byte_mode && bits_ff == `CNT_BITS'(`BYTE_BITS - 1)) begin
              state_ff <= ST_GAP;
              tmr_ff <= 8'(GAP_CYC);
            end
          end
        end
        ST_GAP: begin
          // sync stays low between the two bytes
          if (tmr_done) begin
            state_ff <= ST_SHIFT;
            tmr_ff <= 8'(HALF_CYC - 1);
          end else begin
            tmr_ff <= tmr_ff - 8'h01;
          end
        end
        ST_TRAIL: begin
          if (tmr_done) begin
            state_ff <= ST_REST;
            sync_n_ff <= 1'b1;
            tmr_ff <= 8'(`FRAME_GAP_CYC);
          end else begin
            tmr_ff <= tmr_ff - 8'h01;
          end
        end
        ST_REST: begin
          // keeps sync high long enough for the device to see the edge
          if (tmr_done) begin
            state_ff <= ST_IDLE;
          end else begin
            tmr_ff <= tmr_ff - 8'h01;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // readback sampled at each falling toggle, late in the high phase
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_ff <= `SHIFT_RST;
    end else if (toggle && sclk_ff) begin
      rx_ff <= {rx_ff[`WORD_BITS-2:0], sdo_s2_ff};
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_readback <= `SHIFT_RST;
    end else if (state_ff == ST_TRAIL && tmr_done) begin
      o_readback <= rx_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (state_ff != ST_IDLE) || i_start;
    end
  end

endmodule : dac_load_host

/* verification/dac_link_properties.sv */
// Purpose: timing checks on the host-to-device link
// Assumes: one i_clk domain, sclk seen as data
// Notes: only the first host and device pair is watched, readback and device outputs included
`timescale 1ns/1ps
module dac_link_properties #(
  parameter int DAC_BITS = 12
) (
  // system
  input wire logic i_clk,
  input wire logic i_resetn,
  // link
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic serial_data_out,
  // ends
  input wire logic [DAC_BITS-1:0] o_dac_code,
  input wire logic o_update,
  input wire logic o_sample_rising,
  input wire logic o_busy
);
  logic [4:0] fall_cnt_ff;

  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // falling sclk edges seen in the open frame
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)
      fall_cnt_ff <= 5'h00;
    else if (sync_n)
      fall_cnt_ff <= 5'h00;
    else if ($fell(sclk))
      fall_cnt_ff <= fall_cnt_ff + 5'h01;
  end

  a_sclk_idle_out: assert property (sync_n |-> !sclk)
    else $error("sclk moved outside frame");
  a_idle_sync_high: assert property (!o_busy |-> sync_n)
    else $error("sync low while idle");
  a_frame_sixteen: assert property ($rose(sync_n) |-> fall_cnt_ff == 5'h10)
    else $error("frame not sixteen bits");
  a_sync_lead: assert property ($fell(sync_n) |-> !sclk [*4])
    else $error("sclk too soon after sync");
  // update lands 3 to 6 cycles after sync is first sampled high
  a_update_after_sync: assert property (o_update |-> $past(sync_n, 3) &&
    !($past(sync_n, 5) && $past(sync_n, 6) && $past(sync_n, 7)))
    else $error("update not tied to sync rise");
  a_update_one_cycle: assert property (o_update |=> !o_update)
    else $error("update longer than one cycle");
  a_code_needs_update: assert property ($changed(o_dac_code) |-> o_update)
    else $error("code changed without update");
  a_mode_no_load: assert property ($changed(o_sample_rising) |-> sync_n && !o_update)
    else $error("edge select also loaded code");
  a_din_settled: assert property ((($fell(sclk) && !o_sample_rising) ||
    ($rose(sclk) && o_sample_rising)) |-> $stable(din))
    else $error("data moved at sampling edge");
  a_sdo_on_rise: assert property (($changed(serial_data_out) && !sync_n && !$past(sync_n)) |-> $rose(sclk))
    else $error("readback moved off rising edge");

  c_full_frame: cover property ($rose(sync_n) && fall_cnt_ff == 5'h10);
  c_load: cover property (o_update);
  c_mode_rise: cover property ($rose(o_sample_rising));
endmodule : dac_link_properties

/* verification/test_dac_serial_load_port.sv */
// Purpose: host and device ends joined, plus a directly driven device
// Assumes: host sclk half period shortened to 4 i_clk cycles
// Notes: second device gets short and overlong frames that no host would send
`timescale 1ns/1ps
`include "dac_link_consts.svh"
module test_dac_serial_load_port;
  import dac_link_pkg::*;
  logic clk, resetn, start, byte_mode, rise_mode, busy, upd, upd_b, rmode, rmode_b;
  word_t word, readback, prev;
  logic [11:0] code, code_b, exp_code;
  logic exp_mode, prev_ok;
  int num_errors = 0;
  int cmp_count = 0;
  int upd_cnt = 0;
  int upd_cnt_b = 0;
  int exp_upd = 0;
  word_t ws[7] = '{16'h0ABC, 16'h0123, 16'hE001, 16'h0F0F, 16'h8A5C, 16'hE000, 16'hFFFF};

  dac_link_if link();
  dac_link_if link_b();
  dac_load_host #(.HALF_CYC(4), .GAP_CYC(2)) u_dac_load_host (.i_clk(clk), .i_resetn(resetn),
    .i_start(start), .i_word(word), .i_byte_mode(byte_mode), .i_sample_rising(rise_mode),
    .o_busy(busy), .o_readback(readback), .link(link.host));
  dac_load_device u_dac_load_device (.link(link.dev), .i_clk(clk), .i_resetn(resetn),
    .o_dac_code(code), .o_update(upd), .o_sample_rising(rmode));
  dac_load_device u_dac_load_device_b (.link(link_b.dev), .i_clk(clk), .i_resetn(resetn),
    .o_dac_code(code_b), .o_update(upd_b), .o_sample_rising(rmode_b));
  dac_link_properties #(.DAC_BITS(12)) u_dac_link_properties (.i_clk(clk), .i_resetn(resetn),
    .sync_n(link.sync_n), .sclk(link.sclk), .din(link.din), .serial_data_out(link.serial_data_out),
    .o_dac_code(code), .o_update(upd), .o_sample_rising(rmode), .o_busy(busy));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (upd === 1'b1)
      upd_cnt++;
    if (upd_b === 1'b1)
      upd_cnt_b++;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // one word through the host; waits for idle under a bound
  task automatic send(input word_t w, input logic bm);
    int k = 0;
    start = 1'b1;
    word = w;
    byte_mode = bm;
    rise_mode = exp_mode;
    tick(1);
    start = 1'b0;
    tick(1);
    while (busy !== 1'b0 && k < 2000) begin
      tick(1);
      k++;
    end
    if (busy !== 1'b0) begin
      num_errors++;
      complete_run();
    end
    tick(4);
  endtask : send

  // hand-made frame of nbits, data changed at each rising sclk;
  // the last sixteen bits always carry w, so longer frames exercise the overrun
  task automatic raw_frame(input word_t w, input int nbits);
    link_b.sync_n = 1'b0;
    tick(20);
    for (int i = 0; i < nbits; i++) begin
      link_b.sclk = 1'b1;
      link_b.din = w[(nbits - 1 - i) % 16];
      tick(20);
      link_b.sclk = 1'b0;
      tick(20);
    end
    // released data line must not keep the last bit
    link_b.din = ~link_b.din;
    link_b.sync_n = 1'b1;
    tick(12);
  endtask : raw_frame

  initial begin
    resetn = 1'b0;
    start = 1'b0;
    word = 16'h0000;
    byte_mode = 1'b0;
    rise_mode = 1'b0;
    link_b.sync_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.din = 1'b0;
    exp_code = 12'h000;
    exp_mode = 1'b0;
    prev = `SHIFT_RST;
    prev_ok = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
    tick(1);
    chk("sync_n", 16'h0001, {15'h0000, link.sync_n});
    chk("code", 16'h0000, {4'h0, code});
    for (int i = 0; i < 7; i++) begin
      send(ws[i], i[0]);
      if (ws[i][15:12] == `CTRL_EDGE_SEL)
        exp_mode = ws[i][0];
      else begin
        exp_code = ws[i][11:0];
        exp_upd++;
      end
      chk("code", {4'h0, exp_code}, {4'h0, code});
      chk("mode", {15'h0000, exp_mode}, {15'h0000, rmode});
      chk("updates", exp_upd[15:0], upd_cnt[15:0]);
      // a frame sent in rising mode leaves the shift contents undefined
      if (prev_ok)
        chk("readback", prev, readback);
      prev_ok = !rise_mode;
      prev = ws[i];
    end
    raw_frame(16'h0C3A, 16);
    chk("code_b", 16'h0C3A, {4'h0, code_b});
    raw_frame(16'h0777, 8);
    chk("code_b", 16'h0C3A, {4'h0, code_b});
    chk("updates_b", 16'h0001, upd_cnt_b[15:0]);
    raw_frame(16'h05A5, 20);
    chk("code_b", 16'h05A5, {4'h0, code_b});
    chk("updates_b", 16'h0002, upd_cnt_b[15:0]);
    complete_run();
  end
endmodule : test_dac_serial_load_port
